/* ssep_session_regs.sv */
// session register bank with watchdog and event pin
`timescale 1ns/10ps
`default_nettype none
module ssep_session_regs
(
	// clock, reset, enable
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// host serial side register port
	input  wire logic       host_wr,
	input  wire logic       host_rd,
	input  wire logic [2:0] host_idx,
	input  wire logic [7:0] host_wdata,
	output logic      [7:0] host_rdata,
	input  wire logic       host_claim,
	input  wire logic       host_busy,
	// contactless side register port, read only
	input  wire logic       cl_rd,
	input  wire logic [2:0] cl_idx,
	output logic      [7:0] cl_rdata,
	// contactless activity
	input  wire logic       cl_start,
	input  wire logic       cl_select,
	input  wire logic       cl_halt,
	input  wire logic       cl_read_stb,
	input  wire logic [7:0] cl_read_block,
	input  wire logic       cl_read_last_page,
	input  wire logic       cl_grant_in,
	// buffer and memory state
	input  wire logic       buf_host_ready_in,
	input  wire logic       buf_cl_ready_in,
	input  wire logic       nv_busy_in,
	input  wire logic       nv_hv_fail,
	input  wire logic       auth_limit_in,
	input  wire logic       stretch_cfg_in,
	// pins from outside the clock domain
	input  wire logic       vcc_present_pin,
	input  wire logic       field_pin,
	// outputs
	output logic            event_output_pin,
	output logic      [7:0] session_control,
	output logic      [7:0] last_message_block,
	output logic      [7:0] mirror_window_block,
	output logic            host_memory_grant
);
	//--------------------------------------------------------------------------
	// declarations
	//--------------------------------------------------------------------------
	logic       vcc_meta_ff;
	logic       vcc_s_ff;
	logic       field_meta_ff;
	logic       field_s_ff;
	logic [7:0] ctrl_ff;
	logic [7:0] last_ff;
	logic [7:0] mirror_ff;
	logic [7:0] wdt_lo_ff;
	logic [7:0] wdt_hi_ff;
	logic [1:0] str_ff;
	logic [7:0] stat_ff;
	logic [7:0] host_rdata_ff;
	logic [7:0] cl_rdata_ff;
	logic       host_wr_c;
	logic       msg_hit;
	logic       stat_rd;
	logic       wdt_expire;
	logic       wdt_run;
	logic       event_lvl;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	//--------------------------------------------------------------------------
	// pin synchronisers
	//--------------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			vcc_meta_ff   <= 1'b0;
			vcc_s_ff      <= 1'b0;
			field_meta_ff <= 1'b0;
			field_s_ff    <= 1'b0;
		end
		else if (ce)
		begin
			vcc_meta_ff   <= vcc_present_pin;
			vcc_s_ff      <= vcc_meta_ff;
			field_meta_ff <= field_pin;
			field_s_ff    <= field_meta_ff;
		end

	//--------------------------------------------------------------------------
	// access decode
	//--------------------------------------------------------------------------
	// contactless port has no write path at all
	assign host_wr_c = ce && host_wr;
	assign msg_hit   = cl_read_stb && cl_read_block == last_ff && cl_read_last_page;
	assign stat_rd   = (host_rd && host_idx == ssep_pkg::IDX_STAT) || (cl_rd && cl_idx == ssep_pkg::IDX_STAT);
	assign wdt_run   = vcc_s_ff && stat_ff[ssep_pkg::ST_HGRANT];

	//--------------------------------------------------------------------------
	// session control
	//--------------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
		if (rst)
			ctrl_ff <= ssep_pkg::CTRL_RST;
		else if (ce)
		begin
			if (host_wr && host_idx == ssep_pkg::IDX_CTRL)
				ctrl_ff <= host_wdata;
			// dropping an interface wins over a same-cycle enable
			if (!vcc_s_ff || !field_s_ff)
				ctrl_ff[ssep_pkg::CTL_PTHRU] <= 1'b0;
			if (!vcc_s_ff)
				ctrl_ff[ssep_pkg::CTL_MIRROR] <= 1'b0;
		end

	//--------------------------------------------------------------------------
	// block addresses and watchdog bytes
	//--------------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			last_ff   <= ssep_pkg::LAST_RST;
			mirror_ff <= ssep_pkg::MIRROR_RST;
			wdt_lo_ff <= ssep_pkg::WDT_LO_RST;
			wdt_hi_ff <= ssep_pkg::WDT_HI_RST;
		end
		else if (host_wr_c)
		begin
			if (host_idx == ssep_pkg::IDX_LAST)
				last_ff <= host_wdata;
			if (host_idx == ssep_pkg::IDX_MIRROR)
				mirror_ff <= host_wdata;
			if (host_idx == ssep_pkg::IDX_WDT_LO)
				wdt_lo_ff <= host_wdata;
			if (host_idx == ssep_pkg::IDX_WDT_HI)
				wdt_hi_ff <= host_wdata;
		end

	//--------------------------------------------------------------------------
	// stretch and authentication status
	//--------------------------------------------------------------------------
	// host writes here are dropped; both bits mirror internal state
	always_ff @(posedge clk or posedge rst)
		if (rst)
			str_ff <= ssep_pkg::STR_RST;
		else if (ce)
			str_ff <= {auth_limit_in, stretch_cfg_in};

	//--------------------------------------------------------------------------
	// interface status
	//--------------------------------------------------------------------------
	always_ff @(posedge clk or posedge rst)
		if (rst)
			stat_ff <= ssep_pkg::STAT_RST;
		else if (ce)
		begin
			// a last-page read in the same cycle as a status read survives
			if (msg_hit)
				stat_ff[ssep_pkg::ST_MSG] <= 1'b1;
			else if (stat_rd)
				stat_ff[ssep_pkg::ST_MSG] <= 1'b0;

			if (host_claim)
				stat_ff[ssep_pkg::ST_HGRANT] <= 1'b1;
			else if (wdt_expire || !vcc_s_ff)
				stat_ff[ssep_pkg::ST_HGRANT] <= 1'b0;
			else if (host_wr && host_idx == ssep_pkg::IDX_STAT && !host_wdata[ssep_pkg::ST_HGRANT])
				stat_ff[ssep_pkg::ST_HGRANT] <= 1'b0;

			if (nv_hv_fail)
				stat_ff[ssep_pkg::ST_WERR] <= 1'b1;
			else if (host_wr && host_idx == ssep_pkg::IDX_STAT && !host_wdata[ssep_pkg::ST_WERR])
				stat_ff[ssep_pkg::ST_WERR] <= 1'b0;

			stat_ff[ssep_pkg::ST_CGRANT] <= cl_grant_in;
			stat_ff[ssep_pkg::ST_HREADY] <= buf_host_ready_in;
			stat_ff[ssep_pkg::ST_CREADY] <= buf_cl_ready_in;
			stat_ff[ssep_pkg::ST_WBUSY]  <= nv_busy_in;
			stat_ff[ssep_pkg::ST_FIELD]  <= field_s_ff;
		end

	//--------------------------------------------------------------------------
	// read data
	//--------------------------------------------------------------------------
	function automatic logic [7:0] rd_mux(input logic [2:0] idx);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			ssep_pkg::IDX_CTRL:   v = ctrl_ff;
			ssep_pkg::IDX_LAST:   v = last_ff;
			ssep_pkg::IDX_MIRROR: v = mirror_ff;
			ssep_pkg::IDX_WDT_LO: v = wdt_lo_ff;
			ssep_pkg::IDX_WDT_HI: v = wdt_hi_ff;
			ssep_pkg::IDX_STR:    v = {6'h00, str_ff};
			ssep_pkg::IDX_STAT:   v = stat_ff;
			default:              v = 8'h00;
		endcase
		return v;
	endfunction : rd_mux

	always_ff @(posedge clk or posedge rst)
		if (rst)
			host_rdata_ff <= 8'h00;
		else if (ce && host_rd)
			host_rdata_ff <= rd_mux(host_idx);

	always_ff @(posedge clk or posedge rst)
		if (rst)
			cl_rdata_ff <= 8'h00;
		else if (ce && cl_rd)
			cl_rdata_ff <= rd_mux(cl_idx);

	//--------------------------------------------------------------------------
	// submodules
	//--------------------------------------------------------------------------
	ssep_watchdog u_wdt
	(
		.clk             (clk),
		.rst             (rst),
		.ce              (ce),
		.run             (wdt_run),
		.host_busy       (host_busy),
		.load            (host_wr && host_idx == ssep_pkg::IDX_WDT_HI),
		.time_low        (wdt_lo_ff),
		.time_high_wdata (host_wdata),
		.expire          (wdt_expire)
	);

	ssep_event u_evt
	(
		.clk          (clk),
		.rst          (rst),
		.ce           (ce),
		.assert_sel   (ctrl_ff[ssep_pkg::CTL_ASR_LO +: 2]),
		.release_sel  (ctrl_ff[ssep_pkg::CTL_REL_LO +: 2]),
		.pass_through (ctrl_ff[ssep_pkg::CTL_PTHRU]),
		.dir_to_host  (ctrl_ff[ssep_pkg::CTL_DIR]),
		.field        (field_s_ff),
		.start_pulse  (cl_start),
		.select_pulse (cl_select),
		.halt_pulse   (cl_halt),
		.msg_pulse    (msg_hit),
		.host_ready   (buf_host_ready_in),
		.cl_ready     (buf_cl_ready_in),
		.event_out    (event_lvl)
	);

	//--------------------------------------------------------------------------
	// outputs
	//--------------------------------------------------------------------------
	assign event_output_pin    = event_lvl;
	assign session_control     = ctrl_ff;
	assign last_message_block  = last_ff;
	assign mirror_window_block = mirror_ff;
	assign host_memory_grant   = stat_ff[ssep_pkg::ST_HGRANT];
	assign host_rdata          = host_rdata_ff;
	assign cl_rdata            = cl_rdata_ff;

	//--------------------------------------------------------------------------
	// checks
	//--------------------------------------------------------------------------
	a_pthru_drop: assert property (ce && (!vcc_s_ff || !field_s_ff) |=> !ctrl_ff[6])
		else $error("pass-through kept with interface down");
	a_mirror_drop: assert property (ce && !vcc_s_ff |=> !ctrl_ff[1])
		else $error("mirror kept without host supply");
	a_msg_set: assert property (ce && msg_hit |=> stat_ff[7])
		else $error("message flag not set");
	a_msg_clear: assert property (ce && stat_rd && !msg_hit |=> !stat_ff[7])
		else $error("message flag not cleared by read");
	a_grant_expire: assert property (ce && wdt_expire && !host_claim |=> !stat_ff[6])
		else $error("host grant kept after watchdog");
	a_err_sticky: assert property (ce && nv_hv_fail |=> stat_ff[2] ##1 (stat_ff[2] || $past(host_wr)))
		else $error("write failure flag lost");
	a_rsvd_zero: assert property (ce && cl_rd && cl_idx == 3'h5 |=> cl_rdata_ff[7:2] == 6'h00)
		else $error("reserved stretch bits not zero");
	a_cl_readonly: assert property (ce && !host_wr && vcc_s_ff && field_s_ff |=> $stable(ctrl_ff))
		else $error("control changed without host write");
	a_busy_follow: assert property (ce ##1 ce |-> stat_ff[1] == $past(nv_busy_in))
		else $error("busy bit not following write cycle");

endmodule : ssep_session_regs
`default_nettype wire

/* ssep_pkg.sv */
// constants and types for the session register bank and event pin
//------------------------------------------------------------------------------
// Summary of operation
// - pass-through clears when either interface drops
// - mirror enable clears without host supply
// - event asserts on field, start, or select
// - event releases on field off, halt, message read
// - auth limit status bit, reset zero
// - stretch register upper six bits read zero
// - message flag sets on last read, read clears
// - host grant bit, host writes zero to release
// - contactless grant bit read-only, reset zero
// - buffer ready for host bit
// - buffer ready for contactless bit
// - write failure sticky, host writes zero to clear
// - write busy bit follows nonvolatile cycle
// - field present bit, reset zero
// - event signals new contactless buffer data
// - event signals host buffer data consumed
// - last page read sets flag, releases event
// - high watchdog byte write activates both bytes
// - watchdog expiry clears unreleased host grant
//------------------------------------------------------------------------------
package ssep_pkg;

	//--------------------------------------------------------------------------
	// timing
	//--------------------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 4;
	localparam int          WDT_STEP_NS   = 9430;
	localparam int          WDT_STEP_CYC  = WDT_STEP_NS / CLK_PERIOD_NS;
	localparam logic [11:0] WDT_PRE_LAST  = 12'(WDT_STEP_CYC - 1);

	//--------------------------------------------------------------------------
	// register indices
	//--------------------------------------------------------------------------
	localparam logic [2:0] IDX_CTRL   = 3'h0;
	localparam logic [2:0] IDX_LAST   = 3'h1;
	localparam logic [2:0] IDX_MIRROR = 3'h2;
	localparam logic [2:0] IDX_WDT_LO = 3'h3;
	localparam logic [2:0] IDX_WDT_HI = 3'h4;
	localparam logic [2:0] IDX_STR    = 3'h5;
	localparam logic [2:0] IDX_STAT   = 3'h6;

	//--------------------------------------------------------------------------
	// field positions
	//--------------------------------------------------------------------------
	localparam int CTL_SILENCE = 7;
	localparam int CTL_PTHRU   = 6;
	localparam int CTL_REL_LO  = 4;
	localparam int CTL_ASR_LO  = 2;
	localparam int CTL_MIRROR  = 1;
	localparam int CTL_DIR     = 0;
	localparam int ST_MSG      = 7;
	localparam int ST_HGRANT   = 6;
	localparam int ST_CGRANT   = 5;
	localparam int ST_HREADY   = 4;
	localparam int ST_CREADY   = 3;
	localparam int ST_WERR     = 2;
	localparam int ST_WBUSY    = 1;
	localparam int ST_FIELD    = 0;

	//--------------------------------------------------------------------------
	// reset values
	//--------------------------------------------------------------------------
	localparam logic [7:0]  CTRL_RST       = 8'h00;
	localparam logic [7:0]  LAST_RST       = 8'h00;
	localparam logic [7:0]  MIRROR_RST     = 8'hF8;
	localparam logic [7:0]  WDT_LO_RST     = 8'h48;
	localparam logic [7:0]  WDT_HI_RST     = 8'h08;
	localparam logic [1:0]  STR_RST        = 2'h1;
	localparam logic [7:0]  STAT_RST       = 8'h00;
	localparam logic [15:0] WDT_PERIOD_RST = {WDT_HI_RST, WDT_LO_RST};

	//--------------------------------------------------------------------------
	// event condition encodings
	//--------------------------------------------------------------------------
	typedef enum logic [1:0] {
		ASR_FIELD  = 2'h0,
		ASR_START  = 2'h1,
		ASR_SELECT = 2'h2,
		ASR_PTHRU  = 2'h3
	} ssep_assert_type;

	typedef enum logic [1:0] {
		REL_FIELD = 2'h0,
		REL_HALT  = 2'h1,
		REL_MSG   = 2'h2,
		REL_PTHRU = 2'h3
	} ssep_release_type;

endpackage : ssep_pkg

/* ssep_watchdog.sv */
// watchdog that takes back an unreleased host memory grant
`timescale 1ns/10ps
`default_nettype none
module ssep_watchdog
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// control
	input  wire logic       run,
	input  wire logic       host_busy,
	input  wire logic       load,
	input  wire logic [7:0] time_low,
	input  wire logic [7:0] time_high_wdata,
	// expiry
	output logic            expire
);
	logic [15:0] period_ff;
	logic [11:0] pre_ff;
	logic [15:0] ticks_ff;
	logic        done_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// low byte alone never retimes a running count
	always_ff @(posedge clk or posedge rst)
		if (rst)
			period_ff <= ssep_pkg::WDT_PERIOD_RST;
		else if (ce && load)
			period_ff <= {time_high_wdata, time_low};

	always_ff @(posedge clk or posedge rst)
		if (rst)
		begin
			pre_ff   <= 12'h000;
			ticks_ff <= 16'h0000;
			done_ff  <= 1'b0;
		end
		else if (ce)
		begin
			if (!run)
			begin
				pre_ff   <= 12'h000;
				ticks_ff <= 16'h0000;
				done_ff  <= 1'b0;
			end
			else if (!done_ff)
			begin
				if (pre_ff == ssep_pkg::WDT_PRE_LAST)
				begin
					pre_ff   <= 12'h000;
					ticks_ff <= ticks_ff + 16'h0001;
					if (ticks_ff + 16'h0001 >= period_ff)
						done_ff <= 1'b1;
				end
				else
					pre_ff <= pre_ff + 12'h001;
			end
		end

	// a transfer still running defers the release until it ends
	assign expire = done_ff && !host_busy;

	a_load_takes: assert property (ce && load |=> period_ff == {$past(time_high_wdata), $past(time_low)})
		else $error("watchdog period not loaded");
	a_expire_late: assert property ($rose(done_ff) |-> ticks_ff >= period_ff)
		else $error("watchdog expired early");
	a_stop_clears: assert property (ce && !run |=> !done_ff && ticks_ff == 16'h0000)
		else $error("watchdog kept count without grant");

endmodule : ssep_watchdog
`default_nettype wire

/* ssep_event.sv */
// event output condition selection and pass-through handshake
`timescale 1ns/10ps
`default_nettype none
module ssep_event
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// configuration
	input  wire logic [1:0] assert_sel,
	input  wire logic [1:0] release_sel,
	input  wire logic       pass_through,
	input  wire logic       dir_to_host,
	// contactless activity
	input  wire logic       field,
	input  wire logic       start_pulse,
	input  wire logic       select_pulse,
	input  wire logic       halt_pulse,
	input  wire logic       msg_pulse,
	// buffer state
	input  wire logic       host_ready,
	input  wire logic       cl_ready,
	// output level
	output logic            event_out
);
	logic field_d_ff;
	logic event_ff;
	logic hs;
	logic set_c;
	logic clr_c;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	assign hs        = pass_through && (assert_sel == ssep_pkg::ASR_PTHRU);
	assign event_out = event_ff;

	always_ff @(posedge clk or posedge rst)
		if (rst)
			field_d_ff <= 1'b0;
		else if (ce)
			field_d_ff <= field;

	always_comb
	begin
		set_c = 1'b0;
		unique case (assert_sel)
			ssep_pkg::ASR_FIELD:  set_c = field && !field_d_ff;
			ssep_pkg::ASR_START:  set_c = start_pulse;
			ssep_pkg::ASR_SELECT: set_c = select_pulse;
			ssep_pkg::ASR_PTHRU:  set_c = field && !field_d_ff;
		endcase
	end

	// losing the field ends the event whatever the release selection, except in handshake mode, where hs takes priority
	always_comb
	begin
		clr_c = !field && field_d_ff;
		unique case (release_sel)
			ssep_pkg::REL_FIELD: clr_c = clr_c;
			ssep_pkg::REL_HALT:  clr_c = clr_c || halt_pulse;
			ssep_pkg::REL_MSG:   clr_c = clr_c || msg_pulse;
			ssep_pkg::REL_PTHRU: clr_c = clr_c;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
		if (rst)
			event_ff <= 1'b0;
		else if (ce)
		begin
			if (hs)
				event_ff <= dir_to_host ? host_ready : cl_ready;
			else if (clr_c)
				event_ff <= 1'b0;
			else if (set_c)
				event_ff <= 1'b1;
		end

	a_field_release: assert property (ce && !hs && field_d_ff && !field |=> !event_ff)
		else $error("event not released on field loss");
	a_select_set: assert property (ce && !hs && assert_sel == 2'h2 && select_pulse && !clr_c |=> event_ff)
		else $error("event not asserted on select");
	a_msg_release: assert property (ce && !hs && release_sel == 2'h2 && msg_pulse |=> !event_ff)
		else $error("event not released on message read");
	a_handshake: assert property (ce && hs |=> event_ff == $past(dir_to_host ? host_ready : cl_ready))
		else $error("handshake level wrong");

endmodule : ssep_event
`default_nettype wire

/* ssep_host_model.sv */
// host microcontroller model driving the session register port
`timescale 1ns/10ps
`default_nettype none
module ssep_host_model
(
	// clock
	input  wire logic       clk,
	// register port
	output logic            host_wr,
	output logic            host_rd,
	output logic      [2:0] host_idx,
	output logic      [7:0] host_wdata,
	input  wire logic [7:0] host_rdata
);
	initial
	begin
		host_wr    = 1'b0;
		host_rd    = 1'b0;
		host_idx   = 3'h0;
		host_wdata = 8'h00;
	end

	task automatic wr(input logic [2:0] i, input logic [7:0] v);
		@(posedge clk);
		host_wr    <= 1'b1;
		host_idx   <= i;
		host_wdata <= v;
		@(posedge clk);
		host_wr    <= 1'b0;
		// stale data must not look valid
		host_wdata <= ~v;
	endtask : wr

	task automatic rd(input logic [2:0] i, output logic [7:0] v);
		@(posedge clk);
		host_rd  <= 1'b1;
		host_idx <= i;
		@(posedge clk);
		host_rd <= 1'b0;
		#1;
		v = host_rdata;
	endtask : rd

	// zeros in bits 6 and 2 hand memory back and drop the error
	task automatic release_status();
		wr(3'h6, 8'h00);
	endtask : release_status
endmodule : ssep_host_model
`default_nettype wire

/* testbench.sv */
// self-checking bench of the session register bank and event pin
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic        clk, rst, vcc, field, cl_rd, last_pg, wr, rd, ev, grant, busy;
	logic [5:0]  pl;
	logic [3:0]  lv;
	logic [1:0]  sa;
	logic [2:0]  idx, cl_idx;
	logic [7:0]  wd, hrd, crd, ctl, blk, d, e, lmb, mwb;
	logic [31:0] seed;
	logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'hF8, 8'h48, 8'h08, 8'h01, 8'h01, 8'h00};
	int          fails, samples_checked;

	ssep_host_model hm_u (.clk(clk), .host_wr(wr), .host_rd(rd), .host_idx(idx), .host_wdata(wd), .host_rdata(hrd));
	ssep_session_regs dut_u (.clk(clk), .rst(rst), .ce(1'b1), .host_wr(wr), .host_rd(rd), .host_idx(idx),
		.host_wdata(wd), .host_rdata(hrd), .host_claim(pl[5]), .host_busy(busy), .cl_rd(cl_rd), .cl_idx(cl_idx),
		.cl_rdata(crd), .cl_start(pl[0]), .cl_select(pl[1]), .cl_halt(pl[2]), .cl_read_stb(pl[3]),
		.cl_read_block(blk), .cl_read_last_page(last_pg), .cl_grant_in(lv[3]), .buf_host_ready_in(lv[2]),
		.buf_cl_ready_in(lv[1]), .nv_busy_in(lv[0]), .nv_hv_fail(pl[4]), .auth_limit_in(sa[1]),
		.stretch_cfg_in(sa[0]), .vcc_present_pin(vcc), .field_pin(field), .event_output_pin(ev),
		.session_control(ctl), .last_message_block(lmb), .mirror_window_block(mwb), .host_memory_grant(grant));

	//----
	// helpers
	//----
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction : xs

	function automatic logic [7:0] stat(input logic m, input logic g, input logic r, input logic f);
		return {m, g, lv[3], lv[2], lv[1], r, lv[0], f};
	endfunction : stat

	task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
		samples_checked++;
		if (g !== x)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task automatic rdc(input logic [2:0] i, input logic [7:0] x);
		hm_u.rd(i, d);
		chk("host_rdata", x, d);
	endtask : rdc

	task automatic clc(input logic [2:0] i, input logic [7:0] x);
		@(posedge clk);
		cl_rd  <= 1'b1;
		cl_idx <= i;
		@(posedge clk);
		cl_rd <= 1'b0;
		#1;
		chk("cl_rdata", x, crd);
	endtask : clc

	task automatic pulse(input int b);
		@(posedge clk);
		pl[b] <= 1'b1;
		@(posedge clk);
		pl[b] <= 1'b0;
		repeat (3) @(posedge clk);
	endtask : pulse

	// pin passes a two-flop synchroniser, so allow settling
	task automatic fld(input logic v);
		@(posedge clk);
		field <= v;
		repeat (6) @(posedge clk);
	endtask : fld

	task automatic evc(input logic x);
		chk("event_output_pin", {7'h00, x}, {7'h00, ev});
	endtask : evc

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial
	begin
		repeat (20000) @(posedge clk);
		fails++;
		tally_and_finish();
	end

	initial
	begin
		{rst, vcc, field} = 3'h7;
		{pl, lv, cl_rd, last_pg, cl_idx, blk, busy} = '0;
		sa = 2'h1;
		seed = 32'h1BA0;
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		for (int i = 0; i < 8; i++)
			rdc(3'(i), rv[i]);
		for (int i = 0; i < 12; i++)
		begin
			seed = xs(seed);
			hm_u.wr(3'(1 + i % 5), seed[7:0]);
			e = (i % 5 == 4) ? 8'h01 : seed[7:0];
			rdc(3'(1 + i % 5), e);
			clc(3'(1 + i % 5), e);
			if (i % 5 == 0)
				chk("last_message_block", e, lmb);
			if (i % 5 == 1)
				chk("mirror_window_block", e, mwb);
		end
		repeat (4)
		begin
			seed = xs(seed);
			@(posedge clk);
			{lv, sa} <= seed[5:0];
			repeat (3) @(posedge clk);
			rdc(3'h6, stat(1'b0, 1'b0, 1'b0, 1'b1));
			rdc(3'h5, {6'h00, sa});
		end
		hm_u.wr(3'h1, 8'h21);
		@(posedge clk);
		blk     <= 8'h22;
		last_pg <= 1'b1;
		pulse(3);
		rdc(3'h6, stat(1'b0, 1'b0, 1'b0, 1'b1));
		@(posedge clk);
		blk <= 8'h21;
		pulse(3);
		rdc(3'h6, stat(1'b1, 1'b0, 1'b0, 1'b1));
		rdc(3'h6, stat(1'b0, 1'b0, 1'b0, 1'b1));
		pulse(5);
		pulse(4);
		rdc(3'h6, stat(1'b0, 1'b1, 1'b1, 1'b1));
		hm_u.release_status();
		rdc(3'h6, stat(1'b0, 1'b0, 1'b0, 1'b1));
		for (int a = 1; a < 3; a++)
		begin
			hm_u.wr(3'h0, 8'(8'h10 | (a << 2)));
			// start from a released pin so the assert check can fail
			pulse(2);
			evc(1'b0);
			pulse(a - 1);
			evc(1'b1);
			pulse(2);
			evc(1'b0);
		end
		hm_u.wr(3'h0, 8'h20);
		fld(1'b0);
		fld(1'b1);
		evc(1'b1);
		pulse(3);
		evc(1'b0);
		// code 0 and code 3 of both selections, outside handshake mode
		for (int k = 0; k < 2; k++)
		begin
			hm_u.wr(3'h0, k[0] ? 8'h3C : 8'h00);
			fld(1'b0);
			fld(1'b1);
			evc(1'b1);
			fld(1'b0);
			evc(1'b0);
			fld(1'b1);
		end
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk);
			lv <= {1'b0, i[0], ~i[0], 1'b0};
			hm_u.wr(3'h0, {7'h3E, i[1]});
			repeat (3) @(posedge clk);
			evc(i[1] ? i[0] : ~i[0]);
		end
		// shortest period keeps the expiry wait near 2357 cycles
		hm_u.wr(3'h3, 8'h01);
		hm_u.wr(3'h4, 8'h00);
		pulse(5);
		repeat (2330) @(posedge clk);
		chk("host_memory_grant", 8'h01, {7'h00, grant});
		repeat (40) @(posedge clk);
		chk("host_memory_grant", 8'h00, {7'h00, grant});
		// a running host transfer holds the grant past expiry
		busy <= 1'b1;
		pulse(5);
		repeat (2400) @(posedge clk);
		chk("host_memory_grant", 8'h01, {7'h00, grant});
		busy <= 1'b0;
		repeat (3) @(posedge clk);
		chk("host_memory_grant", 8'h00, {7'h00, grant});
		hm_u.wr(3'h0, 8'h42);
		repeat (2) @(posedge clk);
		chk("session_control", 8'h42, ctl);
		fld(1'b0);
		chk("session_control", 8'h02, ctl);
		fld(1'b1);
		@(posedge clk);
		vcc <= 1'b0;
		repeat (6) @(posedge clk);
		chk("session_control", 8'h00, ctl);
		tally_and_finish();
	end
endmodule : testbench
`default_nettype wire
